// ### vco_cal_defs.svh
// Timing counts, reset values and field positions of the oscillator calibration sequencer
`ifndef VCO_CAL_DEFS_SVH
`define VCO_CAL_DEFS_SVH

// Oscillator octave covered by the bands, in MHz
`define OSC_BAND_LOW_MHZ    15'd7500
`define OSC_BAND_HIGH_MHZ   15'd15000

// Core select values
`define CORE_MIN            3'h1
`define CORE_MAX            3'h7

// Search start points (first trial bit of each successive approximation) and the top band code
`define BAND_TRIAL_START    8'h80
`define BAND_TOP            8'hff
`define BAND_MSB            4'h7
`define AMP_TRIAL_START     9'h100
`define AMP_MSB             4'h8

// Watchdog timeout in phase detector cycles
`define WD_TIMEOUT_PD       16'h1000

// Reset values
`define BAND_RESET          8'h80
`define AMP_RESET           9'h100
`define CORE_RESET          3'h7

// Pin input positions in the synchroniser vector
`define PIN_PD_CLK          0
`define PIN_REF_OK          1
`define PIN_VTUNE_OK        2
`define PIN_FREQ_HIGH       3
`define PIN_AMP_HIGH        4
`define PIN_COUNT           5

`endif

// ### vco_cal_pkg.sv
// Types of the oscillator calibration sequencer
`default_nettype none
package vco_cal_pkg;

   // Frequency related settings, shadowed until the primary control word is written
   typedef struct packed {
      logic [2:0] core_select;
      logic       core_override;
      logic       band_code_override;
      logic       amplitude_code_override;
      logic [7:0] band_code;
      logic [8:0] amplitude_code;
   } freq_cfg_t;

   // Calibration results for readback
   typedef struct packed {
      logic [2:0] core;
      logic [7:0] band_code;
      logic [8:0] amplitude_code;
   } cal_result_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT_REF,
      ST_BAND,
      ST_AMP,
      ST_SETTLE,
      ST_LOCKED,
      ST_LOST,
      ST_FAILED
   } cal_state_t;

endpackage
`default_nettype wire

// ### vco_calibration_sequencer.sv
// Oscillator band and amplitude calibration sequencer with watchdog and relock
//
// Functional notes
// - Primary word write with trigger starts band calibration
// - Primary word write runs amplitude calibration unless amplitude is forced
// - Search selects band suiting the requested frequency
// - Full assist: forced core, band, amplitude used
// - Shadowed writes apply on primary word write
// - Watchdog runs during band and amplitude search when enabled
// - Watchdog expiry restarts, limited by retry limit
// - Sustained lock loss triggers recalibration when enabled
// - Lock delay counts phase detector cycles
// - Lock indication drops on unlock or lost reference
`include "vco_cal_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module vco_calibration_sequencer (
   input  wire logic                    REF_CLK_I,
   input  wire logic                    RESETN_I,
   input  wire logic                    PRIMARY_WR_I,
   input  wire logic                    CAL_TRIGGER_ENABLE_I,
   input  wire logic                    CFG_WR_I,
   input  wire vco_cal_pkg::freq_cfg_t  CFG_I,
   input  wire logic                    SHADOW_WRITE_ENABLE_I,
   input  wire logic                    WATCHDOG_ENABLE_I,
   input  wire logic [3:0]              WATCHDOG_RETRY_LIMIT_I,
   input  wire logic                    RELOCK_RECAL_ENABLE_I,
   input  wire logic [15:0]             LOCK_DELAY_COUNT_I,
   input  wire logic                    PD_CLK_I,
   input  wire logic                    REF_PRESENT_I,
   input  wire logic                    VTUNE_OK_I,
   input  wire logic                    FREQ_HIGH_I,
   input  wire logic                    AMP_HIGH_I,
   output logic                         LOCK_DETECT_O,
   output logic                         CAL_BUSY_O,
   output logic                         CAL_FAILED_O,
   output vco_cal_pkg::freq_cfg_t       ACTIVE_CFG_O,
   output vco_cal_pkg::cal_result_t     RESULT_O,
   output logic [3:0]                   RETRY_COUNT_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, a change counts once stages two and three agree
   logic [`PIN_COUNT-1:0] pin_raw;
   logic [`PIN_COUNT-1:0] pin_s1_r;
   logic [`PIN_COUNT-1:0] pin_s2_r;
   logic [`PIN_COUNT-1:0] pin_s3_r;
   logic [`PIN_COUNT-1:0] pin_r;
   logic                  pd_prev_r;

   assign pin_raw = {AMP_HIGH_I, FREQ_HIGH_I, VTUNE_OK_I, REF_PRESENT_I, PD_CLK_I};

   genvar gi;
   generate
      for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pin
         always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
            if (!RESETN_I) begin
               pin_s1_r[gi] <= 1'b0;
               pin_s2_r[gi] <= 1'b0;
               pin_s3_r[gi] <= 1'b0;
               pin_r[gi]    <= 1'b0;
            end else begin
               pin_s1_r[gi] <= pin_raw[gi];
               pin_s2_r[gi] <= pin_s1_r[gi];
               pin_s3_r[gi] <= pin_s2_r[gi];
               if (pin_s2_r[gi] == pin_s3_r[gi]) begin
                  pin_r[gi] <= pin_s3_r[gi];
               end
            end
         end
      end
   endgenerate

   wire pd_tick   = pin_r[`PIN_PD_CLK] & ~pd_prev_r;
   wire ref_ok    = pin_r[`PIN_REF_OK];
   wire freq_high = pin_r[`PIN_FREQ_HIGH];
   wire amp_high  = pin_r[`PIN_AMP_HIGH];
   wire in_lock   = pin_r[`PIN_VTUNE_OK] & ref_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Shadow registers
   vco_cal_pkg::freq_cfg_t active_r;
   vco_cal_pkg::freq_cfg_t active_nxt;
   vco_cal_pkg::freq_cfg_t pending_r;
   vco_cal_pkg::freq_cfg_t pending_nxt;
   logic                   pending_vld_r;
   logic                   pending_vld_nxt;

   wire cfg_direct = CFG_WR_I & ~SHADOW_WRITE_ENABLE_I;
   wire cfg_shadow = CFG_WR_I & SHADOW_WRITE_ENABLE_I;

   always_comb begin
      pending_nxt     = cfg_shadow ? CFG_I : pending_r;
      pending_vld_nxt = cfg_shadow | (pending_vld_r & ~PRIMARY_WR_I);
      if (cfg_direct) begin
         active_nxt = CFG_I;
      end else if (PRIMARY_WR_I && pending_vld_r) begin
         active_nxt = pending_r;
      end else begin
         active_nxt = active_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration state machine
   vco_cal_pkg::cal_state_t state_r;
   vco_cal_pkg::cal_state_t state_nxt;
   logic [2:0]  core_r;
   logic [2:0]  core_nxt;
   logic [7:0]  band_r;
   logic [7:0]  band_nxt;
   logic [8:0]  amp_r;
   logic [8:0]  amp_nxt;
   logic [3:0]  bit_r;
   logic [3:0]  bit_nxt;
   logic [15:0] wd_cnt_r;
   logic [15:0] wd_cnt_nxt;
   logic [3:0]  retry_r;
   logic [3:0]  retry_nxt;
   logic [15:0] dly_cnt_r;
   logic [15:0] dly_cnt_nxt;
   logic        do_band_r;
   logic        do_band_nxt;

   wire searching  = (state_r == vco_cal_pkg::ST_BAND) || (state_r == vco_cal_pkg::ST_AMP);
   wire wd_expired = WATCHDOG_ENABLE_I && searching && (wd_cnt_r == `WD_TIMEOUT_PD);
   wire relock_hit = (state_r == vco_cal_pkg::ST_LOST) && RELOCK_RECAL_ENABLE_I && pd_tick
                     && (dly_cnt_r >= LOCK_DELAY_COUNT_I);
   wire [7:0] band_bit  = 8'h01 << bit_r[2:0];
   wire [8:0] amp_bit   = 9'h001 << bit_r;
   wire [7:0] band_keep = freq_high ? band_r : (band_r & ~band_bit);
   wire [8:0] amp_keep  = amp_high ? amp_r : (amp_r & ~amp_bit);
   wire [7:0] band_next_bit = (bit_r == 4'h0) ? 8'h00 : (band_bit >> 1);
   wire [8:0] amp_next_bit  = (bit_r == 4'h0) ? 9'h000 : (amp_bit >> 1);
   wire       core_can_step = ~active_r.core_override && (core_r != `CORE_MAX);

   always_comb begin
      state_nxt   = state_r;
      core_nxt    = core_r;
      band_nxt    = band_r;
      amp_nxt     = amp_r;
      bit_nxt     = bit_r;
      wd_cnt_nxt  = (searching && pd_tick) ? wd_cnt_r + 16'h0001 : wd_cnt_r;
      retry_nxt   = retry_r;
      dly_cnt_nxt = dly_cnt_r;
      do_band_nxt = do_band_r;
      if (PRIMARY_WR_I) begin
         state_nxt   = vco_cal_pkg::ST_WAIT_REF;
         do_band_nxt = CAL_TRIGGER_ENABLE_I;
         retry_nxt   = 4'h0;
         wd_cnt_nxt  = 16'h0000;
      end else if (relock_hit) begin
         state_nxt   = vco_cal_pkg::ST_WAIT_REF;
         do_band_nxt = 1'b1;
         retry_nxt   = 4'h0;
         wd_cnt_nxt  = 16'h0000;
      end else if (wd_expired) begin
         wd_cnt_nxt = 16'h0000;
         if (retry_r < WATCHDOG_RETRY_LIMIT_I) begin
            state_nxt = vco_cal_pkg::ST_WAIT_REF;
            retry_nxt = retry_r + 4'h1;
         end else begin
            state_nxt = vco_cal_pkg::ST_FAILED;
         end
      end else begin
         case (state_r)
            vco_cal_pkg::ST_WAIT_REF: begin
               if (ref_ok && pd_tick) begin
                  wd_cnt_nxt = 16'h0000;
                  bit_nxt    = `BAND_MSB;
                  if (do_band_r) begin
                     core_nxt = active_r.core_select;
                     band_nxt = active_r.band_code_override ? active_r.band_code : `BAND_TRIAL_START;
                  end
                  amp_nxt = active_r.amplitude_code_override ? active_r.amplitude_code : `AMP_TRIAL_START;
                  if (do_band_r && !active_r.band_code_override) begin
                     state_nxt = vco_cal_pkg::ST_BAND;
                  end else if (!active_r.amplitude_code_override) begin
                     state_nxt = vco_cal_pkg::ST_AMP;
                     bit_nxt   = `AMP_MSB;
                  end else begin
                     state_nxt   = vco_cal_pkg::ST_SETTLE;
                     dly_cnt_nxt = 16'h0000;
                  end
               end
            end
            vco_cal_pkg::ST_BAND: begin
               if (pd_tick) begin
                  band_nxt = band_keep | band_next_bit;
                  bit_nxt  = bit_r - 4'h1;
                  if (bit_r == 4'h0) begin
                     if ((band_keep == `BAND_TOP) && core_can_step) begin
                        core_nxt = core_r + 3'h1;
                        band_nxt = `BAND_TRIAL_START;
                        bit_nxt  = `BAND_MSB;
                     end else if (!active_r.amplitude_code_override) begin
                        state_nxt = vco_cal_pkg::ST_AMP;
                        bit_nxt   = `AMP_MSB;
                     end else begin
                        state_nxt   = vco_cal_pkg::ST_SETTLE;
                        dly_cnt_nxt = 16'h0000;
                     end
                  end
               end
            end
            vco_cal_pkg::ST_AMP: begin
               if (pd_tick) begin
                  amp_nxt = amp_keep | amp_next_bit;
                  bit_nxt = bit_r - 4'h1;
                  if (bit_r == 4'h0) begin
                     state_nxt   = vco_cal_pkg::ST_SETTLE;
                     dly_cnt_nxt = 16'h0000;
                  end
               end
            end
            vco_cal_pkg::ST_SETTLE: begin
               if (!in_lock) begin
                  dly_cnt_nxt = 16'h0000;
               end else if (dly_cnt_r >= LOCK_DELAY_COUNT_I) begin
                  state_nxt = vco_cal_pkg::ST_LOCKED;
               end else if (pd_tick) begin
                  dly_cnt_nxt = dly_cnt_r + 16'h0001;
               end
            end
            vco_cal_pkg::ST_LOCKED: begin
               if (!in_lock) begin
                  state_nxt   = vco_cal_pkg::ST_LOST;
                  dly_cnt_nxt = 16'h0000;
               end
            end
            vco_cal_pkg::ST_LOST: begin
               if (in_lock) begin
                  state_nxt   = vco_cal_pkg::ST_SETTLE;
                  dly_cnt_nxt = 16'h0000;
               end else if (pd_tick && (dly_cnt_r != 16'hffff)) begin
                  dly_cnt_nxt = dly_cnt_r + 16'h0001;
               end
            end
            vco_cal_pkg::ST_IDLE,
            vco_cal_pkg::ST_FAILED: begin
               state_nxt = state_r;
            end
            default: begin
               state_nxt = vco_cal_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         pd_prev_r     <= 1'b0;
         active_r      <= '0;
         pending_r     <= '0;
         pending_vld_r <= 1'b0;
         state_r       <= vco_cal_pkg::ST_IDLE;
         core_r        <= `CORE_RESET;
         band_r        <= `BAND_RESET;
         amp_r         <= `AMP_RESET;
         bit_r         <= 4'h0;
         wd_cnt_r      <= 16'h0000;
         retry_r       <= 4'h0;
         dly_cnt_r     <= 16'h0000;
         do_band_r     <= 1'b0;
      end else begin
         pd_prev_r     <= pin_r[`PIN_PD_CLK];
         active_r      <= active_nxt;
         pending_r     <= pending_nxt;
         pending_vld_r <= pending_vld_nxt;
         state_r       <= state_nxt;
         core_r        <= core_nxt;
         band_r        <= band_nxt;
         amp_r         <= amp_nxt;
         bit_r         <= bit_nxt;
         wd_cnt_r      <= wd_cnt_nxt;
         retry_r       <= retry_nxt;
         dly_cnt_r     <= dly_cnt_nxt;
         do_band_r     <= do_band_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   wire busy_nxt = (state_nxt == vco_cal_pkg::ST_WAIT_REF) || (state_nxt == vco_cal_pkg::ST_BAND)
                   || (state_nxt == vco_cal_pkg::ST_AMP);

   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         LOCK_DETECT_O <= 1'b0;
         CAL_BUSY_O    <= 1'b0;
         CAL_FAILED_O  <= 1'b0;
         ACTIVE_CFG_O  <= '0;
         RESULT_O      <= '0;
         RETRY_COUNT_O <= 4'h0;
      end else begin
         LOCK_DETECT_O <= (state_nxt == vco_cal_pkg::ST_LOCKED);
         CAL_BUSY_O    <= busy_nxt;
         CAL_FAILED_O  <= (state_nxt == vco_cal_pkg::ST_FAILED);
         ACTIVE_CFG_O  <= active_nxt;
         RESULT_O      <= '{core: core_nxt, band_code: band_nxt, amplitude_code: amp_nxt};
         RETRY_COUNT_O <= retry_nxt;
      end
   end

endmodule
`default_nettype wire

// ### vco_calibration_sequencer_assertions.sv
// Port-level assertions for the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
module vco_cal_assertions (
   input wire logic                   REF_CLK_I,
   input wire logic                   RESETN_I,
   input wire logic                   PRIMARY_WR_I,
   input wire logic                   CFG_WR_I,
   input wire vco_cal_pkg::freq_cfg_t CFG_I,
   input wire logic                   SHADOW_WRITE_ENABLE_I,
   input wire logic                   WATCHDOG_ENABLE_I,
   input wire logic [3:0]             WATCHDOG_RETRY_LIMIT_I,
   input wire logic                   VTUNE_OK_I,
   input wire logic                   LOCK_DETECT_O,
   input wire logic                   CAL_BUSY_O,
   input wire logic                   CAL_FAILED_O,
   input wire vco_cal_pkg::freq_cfg_t ACTIVE_CFG_O,
   input wire logic [3:0]             RETRY_COUNT_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);
   sequence s_primary_write;
      PRIMARY_WR_I;
   endsequence
   sequence s_running;
      CAL_BUSY_O && !LOCK_DETECT_O && !CAL_FAILED_O;
   endsequence
   chk_cal_start_run: assert property (s_primary_write |=> s_running)
      else $error("calibration did not start on primary write");
   chk_direct_cfg: assert property (CFG_WR_I && !SHADOW_WRITE_ENABLE_I |=> ACTIVE_CFG_O == $past(CFG_I))
      else $error("direct settings write not applied");
   chk_shadow_hold: assert property (CFG_WR_I && SHADOW_WRITE_ENABLE_I && !PRIMARY_WR_I |=> $stable(ACTIVE_CFG_O))
      else $error("shadowed settings applied early");
   chk_lock_idle: assert property (LOCK_DETECT_O |-> !CAL_BUSY_O && !CAL_FAILED_O)
      else $error("lock shown while busy or failed");
   chk_fail_quiet: assert property (CAL_FAILED_O |-> !LOCK_DETECT_O && !CAL_BUSY_O)
      else $error("failed state not quiet");
   chk_unlock_drop: assert property (LOCK_DETECT_O && !VTUNE_OK_I |-> ##[1:12] !LOCK_DETECT_O)
      else $error("lock indication kept after loop unlock");
   chk_retry_bound: assert property (RETRY_COUNT_O <= WATCHDOG_RETRY_LIMIT_I)
      else $error("restarts exceed limit");
   chk_retry_step: assert property (RETRY_COUNT_O != $past(RETRY_COUNT_O) |->
      RETRY_COUNT_O == 4'h0 || RETRY_COUNT_O == $past(RETRY_COUNT_O) + 4'h1)
      else $error("restart count jumped");
   chk_fail_cause: assert property ($rose(CAL_FAILED_O) |->
      WATCHDOG_ENABLE_I && RETRY_COUNT_O == WATCHDOG_RETRY_LIMIT_I)
      else $error("failure without exhausted restarts");
endmodule
bind vco_calibration_sequencer vco_cal_assertions vco_cal_assertions_inst (
   .REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .PRIMARY_WR_I(PRIMARY_WR_I), .CFG_WR_I(CFG_WR_I),
   .CFG_I(CFG_I), .SHADOW_WRITE_ENABLE_I(SHADOW_WRITE_ENABLE_I), .WATCHDOG_ENABLE_I(WATCHDOG_ENABLE_I),
   .WATCHDOG_RETRY_LIMIT_I(WATCHDOG_RETRY_LIMIT_I), .VTUNE_OK_I(VTUNE_OK_I), .LOCK_DETECT_O(LOCK_DETECT_O),
   .CAL_BUSY_O(CAL_BUSY_O), .CAL_FAILED_O(CAL_FAILED_O), .ACTIVE_CFG_O(ACTIVE_CFG_O),
   .RETRY_COUNT_O(RETRY_COUNT_O));
`default_nettype wire

// ### vco_pin_model.sv
// Pin-level model of oscillator comparators and loop status
`timescale 1ns/1ps
`default_nettype none
module vco_pin_model (
   input  wire logic                     clk_i,
   input  wire vco_cal_pkg::cal_result_t result_i,
   input  wire vco_cal_pkg::cal_result_t target_i,
   input  wire logic                     ref_on_i,
   input  wire logic                     loop_ok_i,
   output var logic                      pd_clk_o,
   output logic                          ref_present_o,
   output logic                          vtune_ok_o,
   output logic                          freq_high_o,
   output logic                          amp_high_o
);
   logic [1:0] div_r = 2'h0;
   initial pd_clk_o = 1'b0;
   // Phase detector clock, four reference cycles per level
   always @(negedge clk_i) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3) begin
         pd_clk_o <= ~pd_clk_o;
      end
   end
   // Loop lock needs the reference as well
   assign ref_present_o = ref_on_i;
   assign vtune_ok_o    = loop_ok_i && ref_on_i;
   // Cores below target run out of range: every trial bit kept
   assign freq_high_o = (result_i.core < target_i.core) || (result_i.band_code <= target_i.band_code);
   assign amp_high_o  = result_i.amplitude_code <= target_i.amplitude_code;
endmodule
`default_nettype wire

// ### test_vco_calibration_sequencer.sv
// Self-checking bench for the calibration sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
   $display("BAD %0t got %h expected %h", $time, got, exp); end end
module test_vco_calibration_sequencer;
   localparam int LOCK_TICKS = 4;
   logic                     clk = 1'b0, rst_n = 1'b0, prim_wr = 1'b0, trig = 1'b0, cfg_wr = 1'b0;
   logic                     shadow = 1'b0, relock = 1'b0, ref_on = 1'b1, loop_ok = 1'b1;
   vco_cal_pkg::freq_cfg_t   cfg = '0, active, full;
   vco_cal_pkg::cal_result_t target = '0, result;
   logic                     pd_clk, ref_ok, vtune_ok, f_high, a_high, lock, busy, failed;
   logic [3:0]               retries;
   int                       num_errors = 0, tests_run = 0, cycles = 0, n;
   always #4 clk = ~clk;
   vco_calibration_sequencer vco_calibration_sequencer_inst (
      .REF_CLK_I(clk), .RESETN_I(rst_n), .PRIMARY_WR_I(prim_wr), .CAL_TRIGGER_ENABLE_I(trig),
      .CFG_WR_I(cfg_wr), .CFG_I(cfg), .SHADOW_WRITE_ENABLE_I(shadow), .WATCHDOG_ENABLE_I(1'b1),
      .WATCHDOG_RETRY_LIMIT_I(4'h2), .RELOCK_RECAL_ENABLE_I(relock), .LOCK_DELAY_COUNT_I(16'h0004),
      .PD_CLK_I(pd_clk), .REF_PRESENT_I(ref_ok), .VTUNE_OK_I(vtune_ok), .FREQ_HIGH_I(f_high),
      .AMP_HIGH_I(a_high), .LOCK_DETECT_O(lock), .CAL_BUSY_O(busy), .CAL_FAILED_O(failed),
      .ACTIVE_CFG_O(active), .RESULT_O(result), .RETRY_COUNT_O(retries));
   vco_pin_model vco_pin_model_inst (
      .clk_i(clk), .result_i(result), .target_i(target), .ref_on_i(ref_on), .loop_ok_i(loop_ok),
      .pd_clk_o(pd_clk), .ref_present_o(ref_ok), .vtune_ok_o(vtune_ok), .freq_high_o(f_high),
      .amp_high_o(a_high));
   ////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic put_cfg(input vco_cal_pkg::freq_cfg_t c);
      @(negedge clk);
      cfg = c;
      cfg_wr = 1'b1;
      @(negedge clk);
      cfg_wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic prim(input logic t);
      @(negedge clk);
      trig = t;
      prim_wr = 1'b1;
      @(negedge clk);
      prim_wr = 1'b0;
   endtask
   // Bounded wait for a busy and lock pair, cycles waited in n
   task automatic wait_state(input logic wb, input logic wl);
      n = 0;
      @(negedge clk);
      while ({busy, lock} !== {wb, wl} && n < 3000) begin
         @(negedge clk);
         n++;
      end
      `CHECK_EQ({busy, lock}, {wb, wl})
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         $display("BAD %0t run too long", $time);
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      `CHECK_EQ({lock, busy, failed, active}, 26'h0)
      target = '{3'h7, 8'h5a, 9'h0c3};
      put_cfg('{3'h7, 1'b0, 1'b0, 1'b0, 8'h00, 9'h000});
      `CHECK_EQ(active.core_select, 3'h7)
      prim(1'b1);
      wait_state(1'b0, 1'b0);
      wait_state(1'b0, 1'b1);
      `CHECK_EQ(n >= 8 * (LOCK_TICKS - 1) && n <= 8 * LOCK_TICKS + 16, 1'b1)
      `CHECK_EQ(result, target)
      target = '{3'h7, 8'h11, 9'h1e0};
      prim(1'b0);
      wait_state(1'b0, 1'b1);
      `CHECK_EQ(result, vco_cal_pkg::cal_result_t'({3'h7, 8'h5a, 9'h1e0}))
      target = '{3'h5, 8'h33, 9'h077};
      put_cfg('{3'h3, 1'b0, 1'b0, 1'b0, 8'h00, 9'h000});
      prim(1'b1);
      repeat (20) @(negedge clk);
      `CHECK_EQ({busy, lock}, 2'b10)
      prim(1'b1);
      wait_state(1'b0, 1'b1);
      `CHECK_EQ(result, target)
      shadow = 1'b1;
      full = '{3'h2, 1'b1, 1'b1, 1'b1, 8'h3c, 9'h0a5};
      put_cfg(full);
      `CHECK_EQ(active.core_select, 3'h3)
      target = '{3'h2, 8'hc3, 9'h155};
      prim(1'b1);
      @(negedge clk);
      `CHECK_EQ(active, full)
      wait_state(1'b0, 1'b1);
      `CHECK_EQ(result, vco_cal_pkg::cal_result_t'({3'h2, 8'h3c, 9'h0a5}))
      shadow = 1'b0;
      loop_ok = 1'b0;
      repeat (12) @(negedge clk);
      `CHECK_EQ(lock, 1'b0)
      repeat (100) @(negedge clk);
      `CHECK_EQ(busy, 1'b0)
      loop_ok = 1'b1;
      wait_state(1'b0, 1'b1);
      relock = 1'b1;
      loop_ok = 1'b0;
      wait_state(1'b1, 1'b0);
      `CHECK_EQ(n <= 8 * LOCK_TICKS + 24, 1'b1)
      loop_ok = 1'b1;
      wait_state(1'b0, 1'b1);
      `CHECK_EQ(result, vco_cal_pkg::cal_result_t'({3'h2, 8'h3c, 9'h0a5}))
      put_cfg('{3'h2, 1'b1, 1'b1, 1'b1, 8'h3d, 9'h0a6});
      prim(1'b1);
      wait_state(1'b0, 1'b1);
      `CHECK_EQ(result, vco_cal_pkg::cal_result_t'({3'h2, 8'h3d, 9'h0a6}))
      relock = 1'b0;
      ref_on = 1'b0;
      repeat (8) @(negedge clk);
      prim(1'b1);
      repeat (60) @(negedge clk);
      `CHECK_EQ({busy, lock}, 2'b10)
      ref_on = 1'b1;
      wait_state(1'b0, 1'b1);
      `CHECK_EQ({failed, retries}, 5'h00)
      give_verdict();
   end
endmodule
`default_nettype wire
